//--- sim/bus_chip_model.sv
// Behavioural model of the bus interface chip as the host sees it
`timescale 1ns/100ps
module bus_chip_model (
  input  wire logic       mode_sel, // High = unbuffered mode
  input  wire logic       cs_n,     // Chip select, low
  input  wire logic       hsck,     // Host clock, buffered mode
  input  wire logic       pull,     // Host pulls handshake low
  input  wire logic       tx,       // Data from host
  input  wire logic [7:0] flip_at,  // Unit whose echo is inverted
  output logic            dsck,     // Device clock, unbuffered mode
  output logic            dev_pull, // Device holds handshake low
  output logic            rx,       // Data to host
  output logic            busy,     // Bus busy, low when quiet
  output logic [15:0]     seen,     // Last unit put on the bus
  output logic [7:0]      units     // Units put on the bus
);
  logic [15:0] buff;
  logic [15:0] inb;
  int          n;
  time         t_end;
  initial begin
    {dsck, dev_pull, rx, seen, units, inb, n, t_end} = '0;
    buff = 16'ha5c3; // Buffer owned by host after power-on
  end
  // Quiet line falls a while after the bus goes still
  always #100 busy = dev_pull || (t_end != 0 && $time < t_end + 2000);
  // Slave on the host clock, out on rise, in on fall; locked out while bus works
  always @(negedge cs_n) n = 0;
  always @(posedge hsck) if (!cs_n && !mode_sel && !dev_pull) rx = buff[n[3:0]];
  always @(negedge hsck) if (!cs_n && !mode_sel && !dev_pull) begin
    inb[n[3:0]] = tx;
    n = n + 1;
    if (n == 16) buff = inb; // Two-byte swap complete
  end
  // Released select line must not keep the last bit
  always @(posedge cs_n) rx = ~rx;
  // Handshake latches low until the unit is on the bus; no framing flag exists
  always @(posedge pull) begin
    dev_pull = 1;
    if (mode_sel) begin
      @(negedge pull);
      repeat (8) begin // Clock runs only inside a frame, LSB first
        dsck = 1;
        #300 inb = {tx, inb[15:1]};
        rx = tx ^ (units == flip_at);
        dsck = 0;
        #100;
      end
      seen = {8'h00, inb[15:8]};
      rx = ~rx;
    end else begin
      #4000 seen = buff;
      buff = buff ^ {16{units == flip_at}};
    end
    units = units + 8'h01;
    t_end = $time;
    dev_pull = 0; // Handshake high: host owns buffer
  end
endmodule : bus_chip_model

//--- sim/tb_top.sv
// Self-checking bench for the serial bus host controller
`timescale 1ns/100ps
module tb_top;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, perr;
  logic [7:0]  paddr, flip_at, units;
  logic [31:0] pwdata, prdata, rd;
  logic        sck_o, sck_oe, hs_o, hs_oe, bus_tx, cs_n, mode_o;
  logic        dsck, dev_pull, drx, dbusy;
  logic [15:0] seen;
  int          err_count = 0;
  int          checked = 0;
  // Open-drain handshake and shared clock resolved here
  spi_host #(.EOM_CYC(40)) spi_host_inst (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_i(sck_oe ? sck_o : dsck), .sck_o(sck_o),
    .sck_oe(sck_oe), .hs_i(!(hs_oe || dev_pull)), .hs_o(hs_o), .hs_oe(hs_oe),
    .bus_busy_i(dbusy), .bus_transmit_pin(bus_tx), .bus_receive_pin(drx),
    .cs_n(cs_n), .mode_o(mode_o));
  bus_chip_model bus_chip_model_inst (
    .mode_sel(mode_o), .cs_n(cs_n), .hsck(sck_o), .pull(hs_oe), .tx(bus_tx),
    .flip_at(flip_at), .dsck(dsck), .dev_pull(dev_pull), .rx(drx),
    .busy(dbusy), .seen(seen), .units(units));
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk);
    while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // Polls status until the masked bits match
  task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
    do apb(0, 8'h04, 32'h0);
    while ((rd & m) !== v);
  endtask : wait_st
  // Starts a send and checks sticky flags and the unit seen on the bus
  task automatic send(input logic [31:0] c, input logic [7:0] f,
                      input logic [31:0] fl, input logic [15:0] s);
    flip_at <= units + f;
    apb(1, 8'h00, c);
    wait_st(32'h1, 32'h0);
    chk(rd & 32'hf8, fl);
    chk({16'h0, seen}, {16'h0, s});
    apb(1, 8'h04, 32'hf8);
  endtask : send
  task automatic test_done;
    $display("checked %0d, err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  // Watchdog: whole run needs under two thousand cycles
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    test_done;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1;
    flip_at = 8'hff;
    repeat (12) @(posedge mclk);
    rst <= 0;
    chk({28'h0, cs_n, mode_o, hs_oe, sck_oe}, 32'h4);
    repeat (2) @(posedge mclk); // Let the pin synchronisers fill
    apb(0, 8'h04, 32'h0);
    chk(rd, 32'h2);
    apb(0, 8'h20, 32'h0);
    chk(rd | {perr, 31'h0}, 32'h80000000);
    apb(0, 8'h02, 32'h0);
    chk(rd | {perr, 31'h0}, 32'h80000000);
    $display("test registers done");
    apb(1, 8'h10, 32'h5a);
    apb(1, 8'h00, 32'h1); // Enable first: go is taken only when already enabled
    send(32'h5, 8'hff, 32'h08, 16'h005a);
    send(32'h5, 8'h00, 32'h98, 16'h005a);
    apb(0, 8'h08, 32'h0);
    chk(rd & 32'hff, 32'h5a);
    apb(1, 8'h10, 32'h3c5a);
    send(32'h105, 8'h01, 32'h28, 16'h003c);
    $display("test unbuffered done");
    apb(1, 8'h00, 32'h3);
    wait_st(32'h81, 32'h80);
    apb(0, 8'h08, 32'h0);
    chk(rd & 32'hffff, 32'ha5c3);
    chk({31'h0, mode_o}, 32'h0);
    apb(1, 8'h04, 32'hf8);
    apb(1, 8'h10, 32'h1234);
    send(32'h7, 8'hff, 32'h08, 16'h1234);
    chk({31'h0, cs_n}, 32'h1);
    $display("test buffered done");
    apb(1, 8'h00, 32'h7);
    apb(1, 8'h00, 32'hb);
    apb(0, 8'h04, 32'h0);
    chk(rd & 32'h1, 32'h0);
    chk({31'h0, cs_n}, 32'h1);
    $display("test resync done");
    test_done;
  end
endmodule : tb_top

//--- verilog/bit_shifter.sv
// Shift register for one 8- or 16-bit unit, first bit out on the leading edge
`timescale 1ns/100ps
module bit_shifter (
  input  wire logic mclk,  // Clock
  input  wire logic rst,   // Async reset, high
  shift_if.sh       sh     // Sequencer side
);
  typedef struct packed {
    logic [15:0] sr;
    logic [4:0]  cnt;
    logic        out;
  } sh_state_t;
  sh_state_t s, n;
  logic [4:0] len;

  // Bits go out LSB first, same order as on the bus
  always_comb begin
    n   = s;
    len = sh.wide ? 5'd16 : 5'd8;
    if (sh.load) begin
      n.sr  = sh.load_data;
      n.cnt = 5'd0;
    end else begin
      if (sh.lead) n.out = s.sr[0];
      if (sh.trail && s.cnt != len) begin
        n.sr  = sh.wide ? {sh.din, s.sr[15:1]} : {8'h00, sh.din, s.sr[7:1]};
        n.cnt = s.cnt + 5'd1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) s <= '0;
    else     s <= n;
  end

  assign sh.dout  = s.out;
  assign sh.data  = s.sr;
  assign sh.count = s.cnt;
  assign sh.done  = (s.cnt == len);
endmodule : bit_shifter

//--- verilog/shift_if.sv
// Link between the host sequencer and its bit shifter
`timescale 1ns/100ps
interface shift_if;
  logic        load;       // Reload shift register
  logic [15:0] load_data;  // Value to reload
  logic        wide;       // 16-bit unit when high, else 8
  logic        lead;       // Leading sck edge: present next bit
  logic        trail;      // Trailing sck edge: take a bit
  logic        din;        // Synchronised incoming bit
  logic        dout;       // Outgoing bit
  logic [15:0] data;       // Collected unit
  logic [4:0]  count;      // Bits taken so far
  logic        done;       // Unit complete
  modport ctl (output load, load_data, wide, lead, trail, din,
               input dout, data, count, done);
  modport sh  (input load, load_data, wide, lead, trail, din,
               output dout, data, count, done);
endinterface : shift_if

//--- verilog/spi_host.sv
// Host controller for the serial bus interface chip, both SPI modes
//
// What this block does
// - Unbuffered: check quiet and handshake, load byte, pull handshake low to send.
// - Echo matches and message ends: keep bus recessive ten bit times.
// - First echo differs: it is an incoming identifier; retry after quiet again.
// - Later echo differs: collision or noise; resend whole message.
// - Host reinitialises its shift port after a framing error; checksums data.
// - Buffered: host is master, clock idles low, data on first edge.
// - Buffered: chip select low only while a transfer runs.
// - Host sees abort by handshake rising or low at swap end.
// - Host swaps two bytes then pulls handshake low; device latches it.
// - Host watches falling quiet line and rising handshake as edges.
// - A transmit request holds handshake low at least one microsecond.
`timescale 1ns/100ps
module spi_host #(
  parameter int EOM_CYC =
    spi_host_pkg::EOM_BITS * spi_host_pkg::BIT_NS / spi_host_pkg::CLK_NS
) (
  input  wire logic        mclk,             // Clock, 20 MHz
  input  wire logic        rst,              // Async reset, high
  input  wire logic        psel,             // APB select
  input  wire logic        penable,          // APB enable
  input  wire logic        pwrite,           // APB direction
  input  wire logic [7:0]  paddr,            // APB byte address
  input  wire logic [31:0] pwdata,           // APB write data
  output logic      [31:0] prdata,           // APB read data
  output logic             pready,           // APB ready
  output logic             pslverr,          // APB error
  input  wire logic        sck_i,            // Serial clock from device
  output logic             sck_o,            // Serial clock to device
  output logic             sck_oe,           // Host drives serial clock
  input  wire logic        hs_i,             // Handshake line level
  output logic             hs_o,             // Handshake drive value
  output logic             hs_oe,            // Handshake pulled low
  input  wire logic        bus_busy_i,       // Bus-quiet line, low when quiet
  output logic             bus_transmit_pin, // Data to device
  input  wire logic        bus_receive_pin,  // Data from device
  output logic             cs_n,             // Device chip select, low
  output logic             mode_o            // Mode select, low = buffered
);
  localparam int REQ_CYC_I = spi_host_pkg::REQ_CYC;

  typedef struct packed {
    spi_host_pkg::state_t st;
    logic                 en;
    logic                 buf_m;
    logic [2:0]           len;
    logic [3:0][15:0]     msg;
    logic [2:0]           idx;
    logic [15:0]          rx;
    logic [15:0]          sent;
    logic [7:0]           sum;
    logic [4:0]           flags;
    logic                 own;
    logic                 tx;
    logic                 echo;
    logic                 lost;
    logic [15:0]          cnt;
    logic                 sck;
    logic                 cs_n;
    logic                 mode;
    logic                 pull;
    logic [4:0]           hold;
    logic                 sck_p;
    logic                 hs_p;
    logic                 busy_p;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
  } host_state_t;
  host_state_t s, n;

  logic [3:0]  pins_s;
  logic        sck_s, hs_s, busy_s, din_s;
  logic        acc, wr, go, resync, last;
  logic [15:0] nxt;
  logic [31:0] rd;

  shift_if sh ();

  // Pins from the device cross into mclk here
  sync2 #(.W(4)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({sck_i, hs_i, bus_busy_i, bus_receive_pin}),
    .q    (pins_s)
  );
  assign {sck_s, hs_s, busy_s, din_s} = pins_s;

  bit_shifter u_shift (
    .mclk (mclk),
    .rst  (rst),
    .sh   (sh)
  );

  // Unit idx of the message: a byte unbuffered, a word buffered
  function automatic logic [15:0] unit_of(input logic [3:0][15:0] m,
                                          input logic bm, input logic [2:0] i);
    if (bm) unit_of = m[i[1:0]];
    else    unit_of = {8'h00, m[i[2:1]][{i[0], 3'b000} +: 8]};
  endfunction : unit_of

  // Register read value
  always_comb begin
    rd = 32'h0000_0000;
    unique case (paddr)
      spi_host_pkg::CTRL_OFS: begin
        rd[spi_host_pkg::CTRL_EN]                     = s.en;
        rd[spi_host_pkg::CTRL_BUF]                    = s.buf_m;
        rd[spi_host_pkg::CTRL_LEN +: 3]               = s.len;
      end
      spi_host_pkg::STAT_OFS: begin
        rd[spi_host_pkg::STAT_BUSY]                   = (s.st != spi_host_pkg::S_IDLE);
        rd[spi_host_pkg::STAT_HS]                     = hs_s;
        rd[spi_host_pkg::STAT_BBSY]                   = busy_s;
        rd[spi_host_pkg::STAT_FLAG +: 5]              = s.flags;
      end
      spi_host_pkg::RX_OFS:  rd[15:0] = s.rx;
      spi_host_pkg::SUM_OFS: rd[7:0]  = s.sum;
      default: begin
        // Unmapped and unaligned addresses read zero
        if (paddr >= spi_host_pkg::MSG_OFS && paddr <= spi_host_pkg::LAST_OFS &&
            paddr[1:0] == 2'b00) rd[15:0] = s.msg[paddr[3:2]];
      end
    endcase
  end

  always_comb begin
    n            = s;
    sh.load      = 1'b0;
    sh.load_data = 16'h0000;
    sh.wide      = s.buf_m;
    sh.din       = din_s;
    // Unbuffered: the device makes the clock and we follow its edges
    sh.lead      = !s.buf_m && sck_s && !s.sck_p;
    sh.trail     = !s.buf_m && !sck_s && s.sck_p;
    n.sck_p      = sck_s;
    n.hs_p       = hs_s;
    n.busy_p     = busy_s;
    n.hold       = s.pull ? s.hold + 5'd1 : 5'd0;
    last         = (s.idx == s.len);
    nxt          = last ? 16'h0000 : unit_of(s.msg, s.buf_m, s.idx + 3'd1);

    // APB slave: answer one cycle after setup, registers change at access end
    acc       = psel && penable && s.pready;
    wr        = acc && pwrite;
    n.pready  = psel && !penable;
    n.pslverr = psel && !penable && (paddr[1:0] != 2'b00 || paddr > spi_host_pkg::LAST_OFS);
    n.prdata  = (psel && !penable) ? rd : 32'h0000_0000;
    go        = 1'b0;
    resync    = 1'b0;
    if (wr && paddr == spi_host_pkg::CTRL_OFS) begin
      n.en    = pwdata[spi_host_pkg::CTRL_EN];
      n.buf_m = pwdata[spi_host_pkg::CTRL_BUF];
      n.len   = pwdata[spi_host_pkg::CTRL_LEN +: 3];
      go      = pwdata[spi_host_pkg::CTRL_GO];
      resync  = pwdata[spi_host_pkg::CTRL_RESYNC];
    end
    if (wr && paddr == spi_host_pkg::STAT_OFS)
      n.flags = s.flags & ~pwdata[spi_host_pkg::STAT_FLAG +: 5];
    if (wr && paddr == spi_host_pkg::SUM_OFS) n.sum = 8'h00;
    if (wr && paddr >= spi_host_pkg::MSG_OFS && paddr <= spi_host_pkg::LAST_OFS &&
        paddr[1:0] == 2'b00)
      n.msg[paddr[3:2]] = pwdata[15:0];

    // Edges of the handshake and quiet lines drive the sequence
    if (!hs_s) n.own = 1'b0;

    // Unbuffered bytes from other nodes outside our own send
    if (!s.buf_m && sh.done && (s.st == spi_host_pkg::S_IDLE ||
        s.st == spi_host_pkg::S_WAIT_QUIET || s.st == spi_host_pkg::S_WAIT_BUSY ||
        s.st == spi_host_pkg::S_EOM)) begin
      n.rx                       = sh.data;
      n.sum                      = n.sum + sh.data[7:0];
      n.flags[spi_host_pkg::F_RXV] = 1'b1;
      sh.load                    = 1'b1;
    end
    // Handshake rose with a part byte: framing trouble, start the shifter afresh
    if (!s.buf_m && hs_s && !s.hs_p && sh.count != 5'd0 && !sh.done)
      sh.load = 1'b1;

    unique case (s.st)
      spi_host_pkg::S_IDLE: begin
        if (go && s.en) begin
          n.idx = 3'd0;
          n.tx  = 1'b1;
          n.st  = spi_host_pkg::S_WAIT_QUIET;
        end else if (s.en && s.buf_m && hs_s && !s.own && !s.pull) begin
          // Buffer handed to us: unload it, send nothing
          n.tx    = 1'b0;
          n.echo  = 1'b0;
          n.lost  = 1'b0;
          n.cnt   = 16'h0000;
          sh.load = 1'b1;
          n.st    = spi_host_pkg::S_SWAP;
        end
      end
      spi_host_pkg::S_WAIT_QUIET: begin
        if (!busy_s && hs_s) begin
          n.sent       = unit_of(s.msg, s.buf_m, s.idx);
          sh.load      = 1'b1;
          sh.load_data = unit_of(s.msg, s.buf_m, s.idx);
          n.cnt        = 16'h0000;
          n.echo       = 1'b0;
          n.lost       = 1'b0;
          n.st         = s.buf_m ? spi_host_pkg::S_SWAP : spi_host_pkg::S_REQ;
        end
      end
      spi_host_pkg::S_SWAP: begin
        // Host makes sck: low idle, data out on rise, taken on fall
        if (hs_s && !s.hs_p) n.lost = 1'b1;
        if (sh.done && !s.sck) begin
          if (!hs_s || s.lost) begin
            n.flags[spi_host_pkg::F_ABORT] = 1'b1;
            n.idx = 3'd0;
            n.st  = s.tx ? spi_host_pkg::S_WAIT_QUIET : spi_host_pkg::S_IDLE;
          end else begin
            n.own = 1'b1;
            n.rx  = sh.data;
            n.cnt = 16'h0000;
            if (!s.echo && !s.own) begin
              n.flags[spi_host_pkg::F_RXV] = 1'b1;
              n.sum = n.sum + sh.data[7:0] + sh.data[15:8];
            end
            if (!s.tx)       n.st = spi_host_pkg::S_IDLE;
            else if (s.echo) n.st = spi_host_pkg::S_CHECK;
            else             n.st = spi_host_pkg::S_REQ;
          end
        end else if (s.cnt == 16'(spi_host_pkg::SCK_HALF - 1)) begin
          n.cnt    = 16'h0000;
          n.sck    = !s.sck;
          sh.lead  = !s.sck;
          sh.trail = s.sck;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
      spi_host_pkg::S_REQ: begin
        // Pull the handshake long enough for the device to see it
        n.pull = 1'b1;
        n.cnt  = s.cnt + 16'h0001;
        if (s.cnt == 16'(REQ_CYC_I)) begin
          n.pull = 1'b0;
          n.st   = spi_host_pkg::S_WAIT_DONE;
        end
      end
      spi_host_pkg::S_WAIT_DONE: begin
        // Device holds handshake low until the unit is on the bus
        if (hs_s && (s.buf_m || sh.done)) begin
          if (s.buf_m) begin
            n.echo       = 1'b1;
            n.lost       = 1'b0;
            n.cnt        = 16'h0000;
            sh.load      = 1'b1;
            sh.load_data = nxt;
            n.st         = spi_host_pkg::S_SWAP;
          end else begin
            n.rx    = sh.data;
            sh.load = 1'b1;  // Echo used here, so idle states never take it as foreign
            n.st    = spi_host_pkg::S_CHECK;
          end
        end
      end
      spi_host_pkg::S_CHECK: begin
        n.cnt = 16'h0000;
        if (s.rx == s.sent) begin
          if (last) begin
            n.st = spi_host_pkg::S_EOM;
          end else begin
            n.idx  = s.idx + 3'd1;
            n.sent = nxt;
            if (!s.buf_m) begin
              sh.load      = 1'b1;
              sh.load_data = nxt;
            end
            n.st = spi_host_pkg::S_REQ;
          end
        end else if (s.idx == 3'd0) begin
          n.flags[spi_host_pkg::F_ID]  = 1'b1;
          n.flags[spi_host_pkg::F_RXV] = 1'b1;
          n.st = spi_host_pkg::S_WAIT_BUSY;
        end else begin
          n.flags[spi_host_pkg::F_COLL] = 1'b1;
          n.idx = 3'd0;
          n.st  = spi_host_pkg::S_WAIT_QUIET;
        end
      end
      spi_host_pkg::S_WAIT_BUSY: begin
        // Retry only once the foreign message has ended
        if (!busy_s && s.busy_p) n.st = spi_host_pkg::S_WAIT_QUIET;
      end
      spi_host_pkg::S_EOM: begin
        // Bus left recessive: no request for the whole quiet time
        n.cnt = s.cnt + 16'h0001;
        if (s.cnt == 16'(EOM_CYC - 1)) begin
          n.flags[spi_host_pkg::F_DONE] = 1'b1;
          n.tx = 1'b0;
          n.st = spi_host_pkg::S_IDLE;
        end
      end
    endcase

    // Software resync drops the shift port back to its start
    if (resync) begin
      sh.load = 1'b1;
      n.pull  = 1'b0;
      n.sck   = 1'b0;
      n.tx    = 1'b0;
      n.st    = spi_host_pkg::S_IDLE;
    end
    n.cs_n = n.buf_m ? (n.st != spi_host_pkg::S_SWAP) : 1'b0;
    n.mode = ~n.buf_m;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s       <= '0;
      s.st    <= spi_host_pkg::S_IDLE;
      s.len   <= spi_host_pkg::LEN_RST;
      s.flags <= spi_host_pkg::FLG_RST;
      s.mode  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign prdata           = s.prdata;
  assign pready           = s.pready;
  assign pslverr          = s.pslverr;
  assign sck_o            = s.sck;
  assign sck_oe           = s.buf_m;
  assign hs_o             = 1'b0;      // Line is only ever pulled low
  assign hs_oe            = s.pull;
  assign bus_transmit_pin = sh.dout;
  assign cs_n             = s.cs_n;
  assign mode_o           = s.mode;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_miss;
    s.st == spi_host_pkg::S_CHECK && s.rx != s.sent;
  endsequence
  sequence s_swap_end;
    s.st == spi_host_pkg::S_SWAP && sh.done && !s.sck;
  endsequence

  a_req_width: assert property ($fell(s.pull) |-> s.hold >= REQ_CYC_I)
    else $error("handshake request shorter than least time");
  a_req_quiet: assert property (
    $rose(s.pull) && s.idx == 3'd0 && !s.buf_m |-> !$past(busy_s, 2))
    else $error("first request made while bus busy");
  a_cs_swap: assert property (s.buf_m && !s.cs_n |-> s.st == spi_host_pkg::S_SWAP)
    else $error("chip select low outside a swap");
  a_sck_low: assert property (s.st != spi_host_pkg::S_SWAP |-> !s.sck)
    else $error("serial clock not idling low");
  a_id_wait: assert property (
    s_miss ##0 s.idx == 3'd0 |=>
    s.st == spi_host_pkg::S_WAIT_BUSY && s.flags[spi_host_pkg::F_ID])
    else $error("first unit mismatch not treated as identifier");
  a_coll_restart: assert property (
    s_miss ##0 s.idx != 3'd0 |=>
    s.st == spi_host_pkg::S_WAIT_QUIET && s.idx == 3'd0)
    else $error("collision did not restart message");
  a_eom_hold: assert property (
    $rose(s.flags[spi_host_pkg::F_DONE]) |->
    $past(s.st) == spi_host_pkg::S_EOM && $past(s.cnt) == 16'(EOM_CYC - 1))
    else $error("message done without full quiet time");
  a_abort_flag: assert property (
    s_swap_end ##0 !hs_s |=> s.flags[spi_host_pkg::F_ABORT])
    else $error("aborted swap not flagged");
  a_resync_clear: assert property (
    resync |=> sh.count == 5'd0 && s.st == spi_host_pkg::S_IDLE)
    else $error("resync left shifter running");
  a_swap_req: assert property (
    $rose(s.pull) && s.buf_m |->
    $past(s.st, 2) == spi_host_pkg::S_SWAP || $past(s.st, 2) == spi_host_pkg::S_CHECK)
    else $error("buffered request without a swap first");
endmodule : spi_host

//--- verilog/spi_host_pkg.sv
// Constants, register map and types of the serial bus host controller
package spi_host_pkg;
  // Timing
  localparam int CLK_NS   = 50;                            // mclk period
  localparam int REQ_NS   = 1000;                          // Least handshake pull time
  localparam int REQ_CYC  = (REQ_NS + CLK_NS - 1) / CLK_NS; // Rounded up
  localparam int EOM_BITS = 10;                            // Quiet bits ending a message
  localparam int BIT_NS   = 128000;                        // Bus bit time
  localparam int SCK_HALF = 4;                             // mclk cycles per half sck
  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] RX_OFS   = 8'h08;
  localparam logic [7:0] SUM_OFS  = 8'h0c;
  localparam logic [7:0] MSG_OFS  = 8'h10;
  localparam logic [7:0] LAST_OFS = 8'h1c;
  // Control fields
  localparam int CTRL_EN     = 0;
  localparam int CTRL_BUF    = 1;
  localparam int CTRL_GO     = 2;
  localparam int CTRL_RESYNC = 3;
  localparam int CTRL_LEN    = 8;
  // Status fields: sticky flags sit from STAT_FLAG upward
  localparam int STAT_BUSY = 0;
  localparam int STAT_HS   = 1;
  localparam int STAT_BBSY = 2;
  localparam int STAT_FLAG = 3;
  localparam int F_DONE    = 0;
  localparam int F_ID      = 1;
  localparam int F_COLL    = 2;
  localparam int F_ABORT   = 3;
  localparam int F_RXV     = 4;
  // Reset values
  localparam logic [2:0] LEN_RST = 3'h0;
  localparam logic [4:0] FLG_RST = 5'h00;

  typedef enum logic [3:0] {
    S_IDLE, S_WAIT_QUIET, S_SWAP, S_REQ, S_WAIT_DONE, S_CHECK, S_WAIT_BUSY, S_EOM
  } state_t;
endpackage : spi_host_pkg

//--- verilog/sync2.sv
// Two-flop synchroniser for a group of pins
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         mclk,  // Clock
  input  wire logic         rst,   // Async reset, high
  input  wire logic [W-1:0] d,     // Asynchronous inputs
  output logic      [W-1:0] q      // Synchronised outputs
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;
  sync_state_t s, n;

  // First stage feeds only the second
  always_comb begin
    n    = s;
    n.s1 = d;
    n.s2 = s.s1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) s <= '0;
    else     s <= n;
  end

  assign q = s.s2;
endmodule : sync2
